// ---- src/smbq_pkg.sv ----
// Purpose: Shared constants for slow-memory bandwidth and injection QoS
// Assumes: 25 MHz processor clock, register and identification ports
// Notes:   Each number lives here once; smbq_top and the bench import the whole package
package smbq_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] SMBQ_LIMIT_BASE    = 32'hC000_0280; // First per-class limit register
    localparam logic        SMBQ_UNLIMITED_RST = 1'b1;          // Flag set at reset
    localparam logic [63:0] SMBQ_LIMIT_RST     = 64'h0000_0000_0000_0000; // Limit field at reset

    // ----------------------------------------
    // Identification leaves
    // ----------------------------------------
    localparam logic [31:0] SMBQ_BWE_LEAF      = 32'h8000_0020; // Bandwidth-enforcement leaf
    localparam logic [31:0] SMBQ_SUB_FEATURES  = 32'h0000_0000; // Feature bits subleaf
    localparam logic [31:0] SMBQ_SUB_SLOW      = 32'h0000_0002; // Slow-memory attributes subleaf
    localparam logic [31:0] SMBQ_ALLOC_LEAF    = 32'h0000_0010; // Allocation leaf
    localparam logic [31:0] SMBQ_SUB_ALLOC     = 32'h0000_0001; // Cache allocation subleaf
    localparam int          SMBQ_FEAT_SLOW_BIT = 2;             // Slow-memory enforcement present
    localparam int          SMBQ_FEAT_INJ_BIT  = 6;             // Injection enforcement present

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int SMBQ_CLK_PERIOD_NS = 40;  // 25 MHz
    localparam int SMBQ_WINDOW_NS     = 512; // One line per limit unit per window
    localparam int SMBQ_WINDOW_CYC    = SMBQ_WINDOW_NS / SMBQ_CLK_PERIOD_NS; // Rounded down
    localparam int SMBQ_WIN_W         = 8;   // Window counter width
endpackage : smbq_pkg

// ---- src/smbq_class_limiter.sv ----
// Purpose: Per-class slow-memory line budget over one refill window
// Assumes: Window tick and consume come from the same clock domain
// Notes:   Independent per class; no sharing or rescaling between classes
`timescale 1ns/100ps
`default_nettype none
module smbq_class_limiter #(
    parameter int LIMIT_W = 12
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               window_tick,
    input  wire logic               unlimited,
    input  wire logic [LIMIT_W-1:0] limit,
    input  wire logic               consume,
    output logic                    allow
);
    logic [LIMIT_W-1:0] used_reg; // Lines granted in this window

    // ----------------------------------------
    // Budget check
    // ----------------------------------------
    // Unlimited ignores the field entirely
    assign allow = unlimited || (used_reg < limit);

    // Usage counter; a grant on the tick opens the new window with one
    always_ff @(posedge clk) begin
        if (reset) begin
            used_reg <= '0;
        end else if (window_tick) begin
            used_reg <= consume ? LIMIT_W'(1) : '0;
        end else if (consume && !unlimited) begin
            used_reg <= used_reg + LIMIT_W'(1);
        end
    end
endmodule : smbq_class_limiter
`default_nettype wire

// ---- src/smbq_inject_steer.sv ----
// Purpose: Steers I/O-injected lines into allowed cache partitions
// Assumes: Mask of the top class arrives from the cache mask bank
// Notes:   Output mask registered, one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module smbq_inject_steer #(
    parameter int MASK_W = 16
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              enforce,
    input  wire logic [MASK_W-1:0] top_mask,
    input  wire logic              in_valid,
    input  wire logic [MASK_W-1:0] in_mask,
    output logic                   out_valid,
    output logic [MASK_W-1:0]      out_mask
);
    // ----------------------------------------
    // Partition selection
    // ----------------------------------------
    // Enforcing replaces the proposed mask, never merges with it
    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_mask  <= '0;
        end else begin
            out_valid <= in_valid;
            out_mask  <= enforce ? top_mask : in_mask;
        end
    end
endmodule : smbq_inject_steer
`default_nettype wire

// ---- src/smbq_top.sv ----
// Purpose: Slow-memory bandwidth limits per class and injection steering
// Assumes: Register and identification requests are one-cycle pulses
// Notes:   Split mode and injection enable are plain inputs
//
// Functional notes
// - One limit register per class, base plus class
// - Unlimited flag set means limit field ignored
// - Reset sets every unlimited flag
// - Limit field caps class bandwidth, eighth-GB/s units
// - Slow leaf accumulator reports limit field width
// - Slow leaf data register reports highest class
// - Feature bit two shows slow-memory enforcement
// - Split mode uses base plus twice class
// - Behaves like external enforcement, slow memory only
// - Enforcing puts injected lines in designated partitions
// - Designated mask is top class, reported low bits
// - Feature bit six shows injection enforcement
// - Enforcement active only when enable bit one
// - Limits are upper bounds, never rescaled
`timescale 1ns/100ps
`default_nettype none
module smbq_top
    import smbq_pkg::*;
#(
    parameter int NUM_CLASSES = 16, // Classes with a limit register
    parameter int LIMIT_W     = 12, // Width of the limit field
    parameter int MASK_W      = 16, // Cache partition mask width
    parameter int IDX_W       = $clog2(NUM_CLASSES)
) (
    input  wire logic              clk,
    input  wire logic              reset,
    // Register port
    input  wire logic              msr_wr,
    input  wire logic              msr_rd,
    input  wire logic [31:0]       msr_addr,
    input  wire logic [63:0]       msr_wdata,
    output logic                   msr_ack,
    output logic                   msr_fault,
    output logic [63:0]            msr_rdata,
    // Identification port
    input  wire logic              cpuid_req,
    input  wire logic [31:0]       cpuid_leaf,
    input  wire logic [31:0]       cpuid_subleaf,
    output logic                   cpuid_ack,
    output logic [31:0]            cpuid_eax,
    output logic [31:0]            cpuid_ebx,
    output logic [31:0]            cpuid_edx,
    // Mode controls
    input  wire logic              code_data_split_mode,
    input  wire logic              injection_enforce_enable,
    // Slow-memory traffic
    input  wire logic              slow_req_valid,
    input  wire logic [IDX_W-1:0]  slow_req_class,
    output logic                   slow_req_grant,
    // Injected lines
    input  wire logic              inj_valid,
    input  wire logic [MASK_W-1:0] inj_mask,
    input  wire logic [MASK_W-1:0] top_class_mask,
    output logic                   inj_out_valid,
    output logic [MASK_W-1:0]      inj_out_mask
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [LIMIT_W-1:0]     limit_reg [NUM_CLASSES]; // Limit fields
    logic [NUM_CLASSES-1:0] unl_reg;                 // Unlimited flags
    logic [31:0]            msr_offs;                // Address minus base
    logic                   msr_hit;                 // Address in the bank
    logic [IDX_W-1:0]       msr_idx;                 // Bank index
    logic [IDX_W-1:0]       sel_idx;                 // Register serving the request
    logic [NUM_CLASSES-1:0] allow;                   // Per-class budget left
    logic [NUM_CLASSES-1:0] consume;                 // Per-class grant
    logic [SMBQ_WIN_W-1:0]  win_cnt_reg;             // Refill window counter
    logic                   window_tick;             // Window boundary

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign msr_offs = msr_addr - SMBQ_LIMIT_BASE;
    assign msr_hit  = msr_offs < 32'(NUM_CLASSES);
    assign msr_idx  = msr_offs[IDX_W-1:0];

    // Limit bank; flags come up set so nothing throttles early
    always_ff @(posedge clk) begin
        if (reset) begin
            unl_reg <= {NUM_CLASSES{SMBQ_UNLIMITED_RST}};
            for (int i = 0; i < NUM_CLASSES; i++) begin
                limit_reg[i] <= SMBQ_LIMIT_RST[LIMIT_W-1:0];
            end
        end else if (msr_wr && msr_hit) begin
            // Upper bits dropped on write
            limit_reg[msr_idx] <= msr_wdata[LIMIT_W-1:0];
            unl_reg[msr_idx]   <= msr_wdata[LIMIT_W];
        end
    end

    // Read data and answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            msr_ack   <= 1'b0;
            msr_fault <= 1'b0;
            msr_rdata <= '0;
        end else begin
            msr_ack   <= msr_wr || msr_rd;
            // Outside the bank the access is refused
            msr_fault <= (msr_wr || msr_rd) && !msr_hit;
            if (msr_rd && msr_hit) begin
                // Zero above the flag
                msr_rdata <= 64'({unl_reg[msr_idx], limit_reg[msr_idx]});
            end else begin
                msr_rdata <= '0;
            end
        end
    end

    // ----------------------------------------
    // Identification leaves
    // ----------------------------------------
    // External-bandwidth feature bit stays zero: that limiter is elsewhere
    always_ff @(posedge clk) begin
        if (reset) begin
            cpuid_ack <= 1'b0;
            cpuid_eax <= '0;
            cpuid_ebx <= '0;
            cpuid_edx <= '0;
        end else begin
            cpuid_ack <= cpuid_req;
            cpuid_eax <= '0;
            cpuid_ebx <= '0;
            cpuid_edx <= '0;
            if (cpuid_req) begin
                if (cpuid_leaf == SMBQ_BWE_LEAF && cpuid_subleaf == SMBQ_SUB_FEATURES) begin
                    cpuid_ebx[SMBQ_FEAT_SLOW_BIT] <= 1'b1;
                    cpuid_ebx[SMBQ_FEAT_INJ_BIT]  <= 1'b1;
                end else if (cpuid_leaf == SMBQ_BWE_LEAF && cpuid_subleaf == SMBQ_SUB_SLOW) begin
                    cpuid_eax <= 32'(LIMIT_W);
                    cpuid_edx <= 32'(NUM_CLASSES - 1);
                end else if (cpuid_leaf == SMBQ_ALLOC_LEAF && cpuid_subleaf == SMBQ_SUB_ALLOC) begin
                    cpuid_edx <= {16'h0000, 16'(NUM_CLASSES - 1)};
                end
            end
        end
    end

    // ----------------------------------------
    // Bandwidth enforcement
    // ----------------------------------------
    // Split mode doubles the index; classes past half range are
    // software's fault and simply wrap here
    assign sel_idx = code_data_split_mode ? {slow_req_class[IDX_W-2:0], 1'b0}
                                          : slow_req_class;

    // Window boundary; limits are absolute rates, not shares
    always_ff @(posedge clk) begin
        if (reset || window_tick) begin
            win_cnt_reg <= '0;
        end else begin
            win_cnt_reg <= win_cnt_reg + SMBQ_WIN_W'(1);
        end
    end
    assign window_tick = win_cnt_reg == SMBQ_WIN_W'(SMBQ_WINDOW_CYC - 1);

    // Handshake grant is combinational
    assign slow_req_grant = slow_req_valid && allow[sel_idx];

    // One limiter per register, each an upper bound on its own
    for (genvar g = 0; g < NUM_CLASSES; g++) begin : g_lim
        assign consume[g] = slow_req_grant && (sel_idx == IDX_W'(g));
        smbq_class_limiter #(
            .LIMIT_W     (LIMIT_W)
        ) u_lim (
            .clk         (clk),
            .reset       (reset),
            .window_tick (window_tick),
            .unlimited   (unl_reg[g]),
            .limit       (limit_reg[g]),
            .consume     (consume[g]),
            .allow       (allow[g])
        );
    end

    // ----------------------------------------
    // Injection steering
    // ----------------------------------------
    // Enable held by software consistently across processors
    smbq_inject_steer #(
        .MASK_W    (MASK_W)
    ) u_steer (
        .clk       (clk),
        .reset     (reset),
        .enforce   (injection_enforce_enable),
        .top_mask  (top_class_mask),
        .in_valid  (inj_valid),
        .in_mask   (inj_mask),
        .out_valid (inj_out_valid),
        .out_mask  (inj_out_mask)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Named steps shared by the properties below
    sequence s_leaf(logic [31:0] lf, logic [31:0] sl);
        cpuid_req && cpuid_leaf == lf && cpuid_subleaf == sl;
    endsequence

    sequence s_write_unl;
        msr_wr && msr_hit && msr_wdata[LIMIT_W];
    endsequence

    // Any access that misses the bank
    sequence s_out_of_bank;
        (msr_wr || msr_rd) && !msr_hit;
    endsequence

    // Request on a register whose flag is set
    sequence s_unl_req;
        slow_req_valid && unl_reg[sel_idx];
    endsequence

    // Reset and register bank
    property p_reset_unl;
        @(posedge clk) $fell(reset) |-> (&unl_reg);
    endproperty
    a_reset_unl: assert property (p_reset_unl) else $error("flags not set after reset");

    property p_bank_hit;
        @(posedge clk) disable iff (reset)
        msr_rd && msr_addr == SMBQ_LIMIT_BASE + 32'(NUM_CLASSES - 1) |=> msr_ack && !msr_fault;
    endproperty
    a_bank_hit: assert property (p_bank_hit) else $error("last bank register refused");

    property p_fault;
        @(posedge clk) disable iff (reset)
        s_out_of_bank |=> msr_ack && msr_fault && msr_rdata == '0;
    endproperty
    a_fault: assert property (p_fault) else $error("outside access not refused");

    // A refused write must not wrap onto a low class
    property p_no_write;
        @(posedge clk) disable iff (reset)
        msr_wr && !msr_hit |=> $stable(unl_reg);
    endproperty
    a_no_write: assert property (p_no_write) else $error("refused write changed a flag");

    property p_unl_write;
        @(posedge clk) disable iff (reset)
        s_write_unl |=> unl_reg[$past(msr_idx)];
    endproperty
    a_unl_write: assert property (p_unl_write) else $error("unlimited flag not stored");

    // Bandwidth limits and zero upper read bits
    property p_unl_grant;
        @(posedge clk) disable iff (reset)
        s_unl_req |-> slow_req_grant;
    endproperty
    a_unl_grant: assert property (p_unl_grant) else $error("unlimited class throttled");

    property p_zero_cap;
        @(posedge clk) disable iff (reset)
        slow_req_valid && !unl_reg[sel_idx] && limit_reg[sel_idx] == '0 |-> !slow_req_grant;
    endproperty
    a_zero_cap: assert property (p_zero_cap) else $error("grant past zero limit");

    property p_raz;
        @(posedge clk) disable iff (reset)
        msr_rd |=> msr_rdata[63:LIMIT_W+1] == '0;
    endproperty
    a_raz: assert property (p_raz) else $error("upper bits not zero");

    // Identification leaves and split mapping
    property p_width_leaf;
        @(posedge clk) disable iff (reset)
        s_leaf(SMBQ_BWE_LEAF, SMBQ_SUB_SLOW) |=> cpuid_ack && cpuid_eax == 32'(LIMIT_W)
                                                 && cpuid_edx == 32'(NUM_CLASSES - 1);
    endproperty
    a_width_leaf: assert property (p_width_leaf) else $error("slow leaf wrong");

    property p_feat_leaf;
        @(posedge clk) disable iff (reset)
        s_leaf(SMBQ_BWE_LEAF, SMBQ_SUB_FEATURES) |=> cpuid_ebx[SMBQ_FEAT_SLOW_BIT]
                                                     && cpuid_ebx[SMBQ_FEAT_INJ_BIT];
    endproperty
    a_feat_leaf: assert property (p_feat_leaf) else $error("feature bits missing");

    property p_alloc_leaf;
        @(posedge clk) disable iff (reset)
        s_leaf(SMBQ_ALLOC_LEAF, SMBQ_SUB_ALLOC) |=> cpuid_edx[15:0] == 16'(NUM_CLASSES - 1);
    endproperty
    a_alloc_leaf: assert property (p_alloc_leaf) else $error("top class wrong");

    property p_split_map;
        @(posedge clk) disable iff (reset)
        code_data_split_mode |-> sel_idx == IDX_W'({slow_req_class, 1'b0});
    endproperty
    a_split_map: assert property (p_split_map) else $error("split mapping wrong");

    // Injection steering
    property p_inject;
        @(posedge clk) disable iff (reset)
        inj_valid && injection_enforce_enable |=> inj_out_valid && inj_out_mask == $past(top_class_mask);
    endproperty
    a_inject: assert property (p_inject) else $error("injected line not steered");

    property p_no_enforce;
        @(posedge clk) disable iff (reset)
        inj_valid && !injection_enforce_enable |=> inj_out_mask == $past(inj_mask);
    endproperty
    a_no_enforce: assert property (p_no_enforce) else $error("steered while disabled");
endmodule : smbq_top
`default_nettype wire

// ---- tb/smbq_top_test.sv ----
// Purpose: Self-checking bench for slow-memory limits and injection steering
// Assumes: Inputs change on the falling edge; outputs are read before the next rise
// Notes:   Register, identification, traffic and injection scenarios in sequence
`timescale 1ns/100ps
`default_nettype none
module smbq_top_test
    import smbq_pkg::*;
;
    // ----------------------------------------
    // Parameters and signals
    // ----------------------------------------
    localparam int          NC   = 16;                  // Classes under test
    localparam int          LW   = 12;                  // Limit field width
    localparam logic [63:0] FLAG = 64'h1 << LW;         // Unlimited flag value
    logic        clk, reset;                            // Clock and reset
    logic        msr_wr, msr_rd, msr_ack, msr_fault;    // Register handshake
    logic [31:0] msr_addr;                              // Register address
    logic [63:0] msr_wdata, msr_rdata, rd_val;          // Register data
    logic        cpuid_req, cpuid_ack;                  // Identification handshake
    logic [31:0] cpuid_leaf, cpuid_subleaf;             // Leaf selectors
    logic [31:0] cpuid_eax, cpuid_ebx, cpuid_edx;       // Leaf results
    logic        split, inj_en;                         // Mode levels
    logic        slow_req_valid, slow_req_grant;        // Slow traffic
    logic [3:0]  slow_req_class;                        // Requesting class
    logic        inj_valid, inj_out_valid;              // Injection strobes
    logic [15:0] inj_mask, top_class_mask, inj_out_mask; // Partition masks
    int          n_errors, total_checks, cycles, g;      // Bookkeeping

    // ----------------------------------------
    // Device under test
    // ----------------------------------------
    smbq_top #(.NUM_CLASSES(NC), .LIMIT_W(LW), .MASK_W(16)) dut_u (
        .clk(clk), .reset(reset), .msr_wr(msr_wr), .msr_rd(msr_rd), .msr_addr(msr_addr),
        .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_fault(msr_fault), .msr_rdata(msr_rdata),
        .cpuid_req(cpuid_req), .cpuid_leaf(cpuid_leaf), .cpuid_subleaf(cpuid_subleaf),
        .cpuid_ack(cpuid_ack), .cpuid_eax(cpuid_eax), .cpuid_ebx(cpuid_ebx), .cpuid_edx(cpuid_edx),
        .code_data_split_mode(split), .injection_enforce_enable(inj_en),
        .slow_req_valid(slow_req_valid), .slow_req_class(slow_req_class),
        .slow_req_grant(slow_req_grant), .inj_valid(inj_valid), .inj_mask(inj_mask),
        .top_class_mask(top_class_mask), .inj_out_valid(inj_out_valid), .inj_out_mask(inj_out_mask)
    );

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    // Hang guard; the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare seen against expected, four-state exact
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One register cycle; ack and fault stand only in the cycle after the request
    task automatic reg_access(input logic wr, input logic [31:0] addr, input logic [63:0] wdata,
                              input logic exp_fault, output logic [63:0] rdata);
        @(negedge clk);
        msr_wr    <= wr;
        msr_rd    <= !wr;
        msr_addr  <= addr;
        msr_wdata <= wdata;
        @(negedge clk);
        msr_wr <= 1'b0;
        msr_rd <= 1'b0;
        check({63'h0, msr_ack}, 64'h1);
        check({63'h0, msr_fault}, {63'h0, exp_fault});
        rdata = msr_rdata;
    endtask : reg_access

    // One identification request; results are read while ack stands
    task automatic ident(input logic [31:0] leaf, input logic [31:0] sub);
        @(negedge clk);
        cpuid_req     <= 1'b1;
        cpuid_leaf    <= leaf;
        cpuid_subleaf <= sub;
        @(negedge clk);
        cpuid_req <= 1'b0;
        check({63'h0, cpuid_ack}, 64'h1);
    endtask : ident

    // Count grants over one twelve-cycle window of steady requests;
    // align first waits for a budget refill so the count spans exactly one window
    task automatic grants(input logic [3:0] cls, input logic align, output int cnt);
        int i;
        cnt = 0;
        @(negedge clk);
        slow_req_valid <= 1'b1;
        slow_req_class <= cls;
        #10;
        if (align) begin
            for (i = 0; i < 30 && slow_req_grant !== 1'b0; i++) begin
                @(negedge clk);
                #10;
            end
            for (i = 0; i < 30 && slow_req_grant !== 1'b1; i++) begin
                @(negedge clk);
                #10;
            end
        end
        for (i = 0; i < SMBQ_WINDOW_CYC; i++) begin
            if (i > 0) begin
                @(negedge clk);
                #10;
            end
            cnt += int'(slow_req_grant === 1'b1);
        end
        @(negedge clk);
        slow_req_valid <= 1'b0;
    endtask : grants

    // One injected line; the steered mask appears one cycle later
    task automatic inject(input logic en, input logic [15:0] mask);
        @(negedge clk);
        inj_valid <= 1'b1;
        inj_mask  <= mask;
        inj_en    <= en;
        @(negedge clk);
        inj_valid <= 1'b0;
        check({63'h0, inj_out_valid}, 64'h1);
    endtask : inject

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {clk, msr_wr, msr_rd, cpuid_req, split, inj_en, slow_req_valid, inj_valid} = '0;
        {msr_addr, msr_wdata, cpuid_leaf, cpuid_subleaf, slow_req_class} = '0;
        inj_mask       = 16'h0000;
        top_class_mask = 16'h0F0F;
        {n_errors, total_checks, cycles} = '0;
        reset = 1'b1;
        repeat (4) @(negedge clk);
        reset <= 1'b0;
        // Every class starts unlimited with a zero limit
        for (int c = 0; c < NC; c++) begin
            reg_access(1'b0, SMBQ_LIMIT_BASE + 32'(c), 64'h0, 1'b0, rd_val);
            check(rd_val, FLAG);
        end
        // Bits above the flag dropped; neighbour untouched
        reg_access(1'b1, SMBQ_LIMIT_BASE + 32'h3, 64'hFFFF_FFFF_FFFF_F005, 1'b0, rd_val);
        reg_access(1'b0, SMBQ_LIMIT_BASE + 32'h3, 64'h0, 1'b0, rd_val);
        check(rd_val, 64'h0000_0000_0000_1005);
        reg_access(1'b0, SMBQ_LIMIT_BASE + 32'h4, 64'h0, 1'b0, rd_val);
        check(rd_val, FLAG);
        // Just past the bank: refused with zero data; a write there
        // must not wrap onto class zero
        reg_access(1'b0, SMBQ_LIMIT_BASE + 32'(NC), 64'h0, 1'b1, rd_val);
        check(rd_val, 64'h0);
        reg_access(1'b1, SMBQ_LIMIT_BASE + 32'(NC), 64'h0, 1'b1, rd_val);
        reg_access(1'b0, SMBQ_LIMIT_BASE, 64'h0, 1'b0, rd_val);
        check(rd_val, FLAG);
        // Identification leaves
        ident(SMBQ_BWE_LEAF, SMBQ_SUB_FEATURES);
        check({32'h0, cpuid_ebx}, 64'h0000_0000_0000_0044);
        ident(SMBQ_BWE_LEAF, SMBQ_SUB_SLOW);
        check({32'h0, cpuid_eax}, 64'(LW));
        check({32'h0, cpuid_edx}, 64'(NC - 1));
        ident(SMBQ_ALLOC_LEAF, SMBQ_SUB_ALLOC);
        check({48'h0, cpuid_edx[15:0]}, 64'(NC - 1));
        ident(32'h0000_0001, 32'h0000_0000);
        check({32'h0, cpuid_eax}, 64'h0);
        // Limit of two lines per window, then the flag overrides it
        reg_access(1'b1, SMBQ_LIMIT_BASE + 32'h3, 64'h0000_0000_0000_0002, 1'b0, rd_val);
        grants(4'h3, 1'b1, g);
        check(64'(g), 64'h2);
        reg_access(1'b1, SMBQ_LIMIT_BASE + 32'h3, FLAG | 64'h2, 1'b0, rd_val);
        grants(4'h3, 1'b0, g);
        check(64'(g), 64'(SMBQ_WINDOW_CYC));
        // Split mode: class 3 looks up register 6, which allows nothing;
        // class 3 stays inside the halved range
        reg_access(1'b1, SMBQ_LIMIT_BASE + 32'h6, 64'h0, 1'b0, rd_val);
        @(negedge clk);
        split <= 1'b1;
        grants(4'h3, 1'b0, g);
        check(64'(g), 64'h0);
        @(negedge clk);
        split <= 1'b0;
        grants(4'h3, 1'b0, g);
        check(64'(g), 64'(SMBQ_WINDOW_CYC));
        // Injection steered only while enforcement is on
        inject(1'b1, 16'h00FF);
        check({48'h0, inj_out_mask}, 64'h0000_0000_0000_0F0F);
        inject(1'b0, 16'h00FF);
        check({48'h0, inj_out_mask}, 64'h0000_0000_0000_00FF);
        stop_test();
    end
endmodule : smbq_top_test
`default_nettype wire
